// ==== src/pcnt_top.sv ====
/*
  Eight-input pulse counter module logic: static sampling or two 32-bit
  pulse counters, counter clears, thumbwheel decode and status lamps.
  Assumes raw field inputs, switches and thumbwheel are asynchronous; the
  register port and host status inputs are synchronous to mclk.
  // Function
  // - Switch one off static, on counter
  // - Mode switch sampled only at power-up
  // - Static mode reports all eight levels
  // - Counter mode counts lines one and seven
  // - Counting needs host in Modbus mode
  // - Counters increment only, wrap to zero
  // - Counters zeroed at power-up
  // - Holding bits 0/1 clear counters
  // - Half-second companion hold clears counter
  // - Companion lamp lit half second on clear
  // - Pulse lamps toggle; static lamps follow
  // - Fault lamp off, slow, fast, steady
  // - Mode lamp blinks on pending change
  // - Link lamp off, blinking, steady
  // - Thumbwheel decoded into address classes
  // - Type identifier and mode-sized input registers
  // - Holding registers exist in counter mode
*/
module pcnt_top
  import pcnt_pkg::*;
#(
  parameter int unsigned HOLD_CYC     = 32'(pcnt_pkg::HOLD_CLEAR_CYC),
  parameter int unsigned LAMP_CYC     = 32'(pcnt_pkg::CLEAR_LAMP_CYC),
  parameter int unsigned SLOW_CYC     = 32'(pcnt_pkg::SLOW_HALF_CYC),
  parameter int unsigned FAST_CYC     = 32'(pcnt_pkg::FAST_HALF_CYC),
  parameter int unsigned DEB_CYC      = 32'(pcnt_pkg::DEBOUNCE_CYC),
  parameter logic [15:0] STATIC_ID    = 16'h00A1, // arbitrary value
  parameter logic [15:0] COUNT_ID     = 16'h00B2  // arbitrary value
) (
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Field inputs and front controls (asynchronous)
  input  wire logic [7:0]  input_line,
  input  wire logic        mode_switch,
  input  wire logic [7:0]  thumbwheel_bcd,
  // Host side status (synchronous)
  input  wire logic        host_modbus_mode,
  input  wire logic        link_configuring,
  input  wire logic        link_cyclic,
  input  wire logic        link_comm_lost,
  input  wire logic        internal_error,
  // Register port
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic        reg_holding,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  output logic             reg_ack,
  output logic             reg_err,
  // Address decode
  output logic [6:0]       io_pairing_address,
  output logic [3:0]       tw_class,
  // Lamps
  output logic [7:0]       input_lamp,
  output logic             fault_lamp,
  output logic             counter_mode_lamp,
  output logic             link_lamp,
  output logic             power_lamp
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [7:0]  s1, s2;          // synchroniser stages for the inputs
    logic [1:0]  m1, m2;          // mode switch sync; bit 1 marks a real sample
    logic [7:0]  t1, t2;          // thumbwheel sync
    logic        mode_cnt;        // applied mode, held from power-up
    logic        cap_done;        // power-up capture already taken
    logic [1:0]  deb;             // debounced counting inputs
    logic [1:0][19:0] debc;       // debounce counters
    logic [1:0][31:0] cnt;
    logic [1:0]  plamp;           // pulse toggle lamps
    logic [1:0][27:0] hold;       // companion hold counters
    logic [1:0]  held;            // hold already acted on
    logic [1:0][27:0] lamp;       // clear indication timers
    logic [15:0] hreg0, hreg1;
    logic [7:0]  tw_base;         // thumbwheel at power-up
    logic        tw_chg;
    logic [27:0] blink;
    logic        slow_ph, fast_ph;
    logic [27:0] fblink;
    logic [15:0] rdata;
    logic        ack, err;
  } pcnt_st_t;

  pcnt_st_t st_r, st_nxt;

  // Digit decode used for the power-up value only; the live value is compared raw
  function automatic logic [3:0] pcnt_tw_dec(input logic [7:0] v);
    if (v == 8'h00)
      pcnt_tw_dec = PCNT_TW_DELIVERY;
    else if (v[7:4] <= 4'h9 && v[3:0] <= 4'h9)
      pcnt_tw_dec = PCNT_TW_PAIRING;
    else if (v[7:4] > 4'h9 && v[3:0] >= 4'h1 && v[3:0] <= 4'h9)
      pcnt_tw_dec = PCNT_TW_SLAVE;
    else
      pcnt_tw_dec = PCNT_TW_BAD;
  endfunction : pcnt_tw_dec

  logic       count_on;
  logic [1:0] deb_raw;
  logic [1:0] comp_raw;
  logic [1:0] clr_wr;

  assign count_on = st_r.mode_cnt & host_modbus_mode;
  assign deb_raw  = {st_r.s2[6], st_r.s2[0]};
  assign comp_raw = {st_r.s2[4], st_r.s2[2]};
  // Each accepted write with a bit at one clears; no self-clear needed
  assign clr_wr   = (ce && reg_wr && reg_holding && st_r.mode_cnt
                     && reg_addr == HOLD_CLR_OFS)
                    ? {reg_wdata[CLR_SEVEN_BIT], reg_wdata[CLR_ONE_BIT]}
                    : 2'b00;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic [1:0] rise;
    logic [1:0] clr;
    logic [3:0] nregs;
    rise   = 2'b00;
    clr    = 2'b00;
    nregs  = 4'h0;
    st_nxt = st_r;
    // Two-stage synchronisers; stage one feeds stage two only
    st_nxt.s1 = input_line;
    st_nxt.s2 = st_r.s1;
    st_nxt.m1 = {1'b1, mode_switch};
    st_nxt.m2 = st_r.m1;
    st_nxt.t1 = thumbwheel_bcd;
    st_nxt.t2 = st_r.t1;
    // Latch mode and address once after power-up, never again.
    // Bit 1 of the switch stage only rises once the synchroniser holds
    // a real sample, so the capture never sees the reset zero; a later
    // lever change only shows as a pending indication on the lamps
    if (st_r.m2[1] && !st_r.cap_done) begin
      st_nxt.cap_done = 1'b1;
      st_nxt.mode_cnt = st_r.m2[0];
      st_nxt.tw_base  = st_r.t2;
    end
    // Fast blink timebase, shared by fault and link lamps
    if (st_r.fblink >= 28'(FAST_CYC)) begin
      st_nxt.fblink  = 28'h0;
      st_nxt.fast_ph = ~st_r.fast_ph;
    end else begin
      st_nxt.fblink = st_r.fblink + 28'h1;
    end
    // Slow blink timebase
    if (st_r.blink >= 28'(SLOW_CYC)) begin
      st_nxt.blink   = 28'h0;
      st_nxt.slow_ph = ~st_r.slow_ph;
    end else begin
      st_nxt.blink = st_r.blink + 28'h1;
    end
    st_nxt.tw_chg = st_r.cap_done && (st_r.t2 != st_r.tw_base);
    // Per counter: debounce, count, companion hold, clear lamp
    for (int i = 0; i < 2; i++) begin
      if (deb_raw[i] == st_r.deb[i]) begin
        st_nxt.debc[i] = 20'h0;
      end else if (st_r.debc[i] >= 20'(DEB_CYC)) begin
        st_nxt.debc[i] = 20'h0;
        st_nxt.deb[i]  = deb_raw[i];
        rise[i]        = deb_raw[i];
      end else begin
        st_nxt.debc[i] = st_r.debc[i] + 20'h1;
      end
      if (comp_raw[i] && count_on) begin
        if (st_r.hold[i] >= 28'(HOLD_CYC - 1)) begin
          clr[i]         = !st_r.held[i];
          st_nxt.held[i] = 1'b1;
        end else begin
          st_nxt.hold[i] = st_r.hold[i] + 28'h1;
        end
      end else begin
        st_nxt.hold[i] = 28'h0;
        st_nxt.held[i] = 1'b0;
      end
      clr[i] = clr[i] | clr_wr[i];
      if (clr[i])
        st_nxt.cnt[i] = 32'h0;
      else if (rise[i] && count_on)
        st_nxt.cnt[i] = st_r.cnt[i] + 32'h1;
      if (rise[i] && count_on)
        st_nxt.plamp[i] = ~st_r.plamp[i];
      if (clr[i])
        st_nxt.lamp[i] = 28'(LAMP_CYC);
      else if (st_r.lamp[i] != 28'h0)
        st_nxt.lamp[i] = st_r.lamp[i] - 28'h1;
    end
    // Register port, one-cycle answer
    // Counter words are read live: a carry between two reads can tear
    st_nxt.ack   = 1'b0;
    st_nxt.err   = 1'b0;
    st_nxt.rdata = 16'h0000;
    nregs = st_r.mode_cnt ? COUNT_NREGS : STATIC_NREGS;
    if (reg_rd || reg_wr) begin
      st_nxt.ack = 1'b1;
      if (reg_holding) begin
        if (!st_r.mode_cnt || reg_addr >= HOLD_NREGS) begin
          st_nxt.err = 1'b1;
        end else if (reg_wr) begin
          if (reg_addr == HOLD_SPARE_OFS)
            st_nxt.hreg0 = reg_wdata;
          else
            st_nxt.hreg1 = reg_wdata;
        end else begin
          st_nxt.rdata = (reg_addr == HOLD_SPARE_OFS) ? st_r.hreg0 : st_r.hreg1;
        end
      end else if (reg_wr || reg_addr >= nregs) begin
        st_nxt.err = 1'b1;
      end else begin
        case (reg_addr)
          IN_TYPE_OFS:    st_nxt.rdata = st_r.mode_cnt ? COUNT_ID : STATIC_ID;
          IN_LEVELS_OFS:  st_nxt.rdata = {8'h00, st_r.s2};
          IN_CNT1_HI_OFS: st_nxt.rdata = st_r.cnt[0][31:16];
          IN_CNT1_LO_OFS: st_nxt.rdata = st_r.cnt[0][15:0];
          IN_CNT7_HI_OFS: st_nxt.rdata = st_r.cnt[1][31:16];
          IN_CNT7_LO_OFS: st_nxt.rdata = st_r.cnt[1][15:0];
          default:        st_nxt.err   = 1'b1;
        endcase
      end
    end
    if (!ce)
      st_nxt = st_r;
  end

  // ==========================================================================
  // Register the state; power-up clears counters
  // ==========================================================================
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r       <= '0;
      st_r.hreg1 <= HOLD_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic pending;
  logic [3:0] twc;
  assign pending   = st_r.cap_done && (st_r.m2[0] != st_r.mode_cnt);
  assign twc       = pcnt_tw_dec(st_r.tw_base);
  assign tw_class  = twc;
  assign io_pairing_address = (twc == PCNT_TW_PAIRING)
                              ? 7'(st_r.tw_base[7:4] * 4'hA + st_r.tw_base[3:0])
                              : 7'h00;
  assign reg_rdata = st_r.rdata;
  assign reg_ack   = st_r.ack;
  assign reg_err   = st_r.err;
  assign power_lamp = 1'b1;

  // Lamps: counter mode shows pulses and clears, static follows levels
  always_comb begin
    input_lamp = st_r.s2;
    if (st_r.mode_cnt) begin
      input_lamp    = 8'h00;
      input_lamp[0] = st_r.plamp[0];
      input_lamp[6] = st_r.plamp[1];
      input_lamp[2] = st_r.lamp[0] != 28'h0;
      input_lamp[4] = st_r.lamp[1] != 28'h0;
    end
  end

  // Priority: critical error, lost link, pending change
  always_comb begin
    if (internal_error)
      fault_lamp = 1'b1;
    else if (link_comm_lost)
      fault_lamp = st_r.fast_ph;
    else if (st_r.tw_chg || pending)
      fault_lamp = st_r.slow_ph;
    else
      fault_lamp = 1'b0;
  end

  assign counter_mode_lamp = pending ? st_r.slow_ph : st_r.mode_cnt;

  always_comb begin
    if (link_cyclic)
      link_lamp = 1'b1;
    else if (link_configuring)
      link_lamp = st_r.fast_ph;
    else
      link_lamp = 1'b0;
  end

endmodule : pcnt_top

// ==== shared/pcnt_pkg.sv ====
/*
  Package for the eight-input pulse counter block: register offsets, field
  positions, reset values, lamp timing and the thumbwheel and link lamp encodings.
  Assumes a 250 MHz module clock and a register port driven by the host
  side logic that carries Modbus input and holding register accesses.
*/
package pcnt_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ           = 250_000_000;
  localparam int unsigned HOLD_CLEAR_MS    = 500;   // companion input hold time
  localparam int unsigned CLEAR_LAMP_MS    = 500;   // clear indication time
  localparam int unsigned SLOW_BLINK_MHZ   = 1400;  // 1.4 Hz in millihertz
  localparam int unsigned FAST_BLINK_MHZ   = 2800;  // 2.8 Hz in millihertz
  localparam int unsigned MODE_BLINK_MHZ   = 1400;
  localparam int unsigned LINK_BLINK_MHZ   = 2800;
  localparam int unsigned MAX_PULSE_HZ     = 100;
  localparam int unsigned DEBOUNCE_US      = 1000;  // well under half a 100 Hz period
  // Derived cycle counts: least times round up, half periods round down
  localparam longint HOLD_CLEAR_CYC = (longint'(CLK_HZ) * HOLD_CLEAR_MS + 999) / 1000;
  localparam longint CLEAR_LAMP_CYC = (longint'(CLK_HZ) * CLEAR_LAMP_MS + 999) / 1000;
  localparam longint SLOW_HALF_CYC  = (longint'(CLK_HZ) * 1000) / (2 * SLOW_BLINK_MHZ);
  localparam longint FAST_HALF_CYC  = (longint'(CLK_HZ) * 1000) / (2 * FAST_BLINK_MHZ);
  localparam longint DEBOUNCE_CYC   = (longint'(CLK_HZ) * DEBOUNCE_US + 999_999) / 1_000_000;

  // ==========================================================================
  // Register map (word index within the block's area)
  // ==========================================================================
  localparam logic [3:0] IN_TYPE_OFS    = 4'h0; // input register 30xx0
  localparam logic [3:0] IN_LEVELS_OFS  = 4'h1; // input register 30xx1
  localparam logic [3:0] IN_CNT1_HI_OFS = 4'h2; // input register 30xx2
  localparam logic [3:0] IN_CNT1_LO_OFS = 4'h3;
  localparam logic [3:0] IN_CNT7_HI_OFS = 4'h4;
  localparam logic [3:0] IN_CNT7_LO_OFS = 4'h5;
  localparam logic [3:0] HOLD_SPARE_OFS = 4'h0; // holding register 40xx0
  localparam logic [3:0] HOLD_CLR_OFS   = 4'h1; // holding register counter_clear_control
  localparam int unsigned CLR_ONE_BIT   = 0;
  localparam int unsigned CLR_SEVEN_BIT = 1;
  localparam logic [15:0] HOLD_RESET    = 16'h0000;
  localparam logic [3:0] STATIC_NREGS   = 4'h2;
  localparam logic [3:0] COUNT_NREGS    = 4'h6;
  localparam logic [3:0] HOLD_NREGS     = 4'h2;

  // Thumbwheel decode classes
  typedef enum logic [3:0] {
    PCNT_TW_DELIVERY = 4'b0001,
    PCNT_TW_PAIRING  = 4'b0010,
    PCNT_TW_SLAVE    = 4'b0100,
    PCNT_TW_BAD      = 4'b1000
  } pcnt_tw_t;

  // Link lamp states
  typedef enum logic [2:0] {
    PCNT_LK_IDLE   = 3'b001,
    PCNT_LK_CONFIG = 3'b010,
    PCNT_LK_CYCLIC = 3'b100
  } pcnt_link_t;

endpackage : pcnt_pkg

// ==== test/pcnt_monitor.sv ====
/* Checker bound to pcnt_top: register answers, clear lamps, decode, lamps.
   Assumes it sees only the ports of pcnt_top. */
module pcnt_monitor
  import pcnt_pkg::*;
(
  // Clock, reset, register port
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic        reg_holding,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_ack,
  input wire logic        reg_err,
  // Decode and lamps
  input wire logic [3:0]  tw_class,
  input wire logic [6:0]  io_pairing_address,
  input wire logic [7:0]  input_lamp,
  input wire logic        fault_lamp,
  input wire logic        internal_error,
  input wire logic        link_lamp,
  input wire logic        link_configuring,
  input wire logic        link_cyclic
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Register port
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // A taken request
  sequence req_s;
    ce && (reg_rd || reg_wr);
  endsequence
  // Accepted clear write; b picks the counter bit
  sequence clr_s(b);
    req_s ##0 reg_wr && reg_holding && reg_addr == HOLD_CLR_OFS && reg_wdata[b]
      ##1 reg_ack && !reg_err;
  endsequence
  ack_timing_a: assert property (req_s |=> reg_ack)
    else $error("no answer one cycle after request");
  ack_idle_a: assert property (!(ce && (reg_rd || reg_wr)) |=> !reg_ack)
    else $error("answer without request");
  err_ack_a: assert property (reg_err |-> reg_ack)
    else $error("error flag outside an answer");
  // Lamp must already be lit on the answer, or one cycle later at worst
  clr_one_a: assert property (clr_s(CLR_ONE_BIT) |-> ##[0:1] input_lamp[2] [*8])
    else $error("line three lamp not lit after clear");
  clr_seven_a: assert property (clr_s(CLR_SEVEN_BIT) |-> ##[0:1] input_lamp[4] [*8])
    else $error("line five lamp not lit after clear");
  // ==========================================================================
  // Decode and lamps
  tw_onehot_a: assert property ($onehot(tw_class))
    else $error("address class not one-hot");
  pair_zero_a: assert property (tw_class != PCNT_TW_PAIRING |-> io_pairing_address == 7'h00)
    else $error("pairing address outside pairing class");
  pair_range_a: assert property (tw_class == PCNT_TW_PAIRING |->
    io_pairing_address inside {[7'h01:7'h63]}) else $error("pairing address out of range");
  link_off_a: assert property ((!link_configuring && !link_cyclic) [*3] |-> !link_lamp)
    else $error("link lamp lit without communication");
  fault_on_a: assert property (internal_error [*3] |-> fault_lamp)
    else $error("fault lamp dark on internal error");
endmodule : pcnt_monitor

bind pcnt_top pcnt_monitor u_mon (.*);

// ==== test/pcnt_mb_master.sv ====
/* Modbus master model on the register port of pcnt_top.
   Assumes one request at a time, answered within four cycles. */
module pcnt_mb_master (
  // Clock and answer
  input  wire logic  mclk,
  input  wire logic  reg_ack,
  // Request
  output logic       reg_rd,
  output logic       reg_wr,
  output logic       reg_holding,
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle address and data lines carry the inverse of the last value; holding keeps its value
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_holding = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
  end
  // One request after a random gap, so answers meet prompt and slow masters
  task automatic xfer(input logic w, h, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = $urandom_range(3, 0);
    repeat (n + 1) @(posedge mclk);
    #1;
    reg_wr = w;
    reg_rd = !w;
    reg_holding = h;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    n = 0;
    while (reg_ack !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask : xfer
endmodule : pcnt_mb_master

// ==== test/tb_top.sv ====
/* Testbench for pcnt_top: static and counter modes through the register port.
   Assumes pcnt_mb_master as the far side and the bound checker. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pcnt_pkg::*;
  typedef struct {logic [15:0] d; logic e; logic c;} pcnt_exp_t;
  localparam logic [15:0] S_ID = 16'h0A5C; // arbitrary value
  localparam logic [15:0] C_ID = 16'h0C3A; // arbitrary value
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, mode_switch = 1'b0, host_modbus_mode = 1'b1;
  logic link_configuring = 1'b0, link_cyclic = 1'b0, link_comm_lost = 1'b0;
  logic internal_error = 1'b0, reg_rd, reg_wr, reg_holding, reg_ack, reg_err, l, f;
  logic fault_lamp, counter_mode_lamp, link_lamp, power_lamp;
  logic [7:0] input_line = 8'h00, thumbwheel_bcd = 8'h00, input_lamp, lvl;
  logic [3:0] reg_addr, tw_class;
  logic [15:0] reg_wdata, reg_rdata;
  logic [6:0] io_pairing_address;
  pcnt_exp_t exq[$];
  pcnt_exp_t x;
  int failures = 0, n_checks = 0, cyc_cnt = 0, n;
  pcnt_top #(.HOLD_CYC(20), .LAMP_CYC(20), .SLOW_CYC(16), .FAST_CYC(8), .DEB_CYC(3),
    .STATIC_ID(S_ID), .COUNT_ID(C_ID)) u_dut (.*);
  pcnt_mb_master u_mst (.*);
  // ==========================================================================
  // Clock, timeout, answer checking
  initial begin
    forever #2 mclk = ~mclk;
  end
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish();
    end
  end
  // Oldest note against each answer
  always @(posedge mclk) begin
    if (reg_ack === 1'b1) begin
      if (exq.size() == 0) begin
        failures++;
        $display("[ERR] %0t answer without request", $time);
      end else begin
        x = exq.pop_front();
        n_checks++;
        if (reg_err !== x.e || (x.c && reg_rdata !== x.d)) begin
          failures++;
          $display("[ERR] %0t answer %h/%b, expected %h/%b", $time,
                   reg_rdata, reg_err, x.d, x.e);
        end
      end
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t value %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // ==========================================================================
  // Stimulus helpers
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc
  // Note the expectation, then let the master issue it; d is read data or write data
  task automatic xf(input logic w, h, input logic [3:0] a, input logic [15:0] d, input logic e);
    exq.push_back('{d, e, !w && !e});
    u_mst.xfer(w, h, a, d);
  endtask : xf
  // Pulses well above debounce, 20 cycles a period, faster than the 100 Hz scale
  task automatic pulse(input int b, k);
    repeat (k) begin
      input_line[b] = 1'b1;
      cyc(10);
      input_line[b] = 1'b0;
      cyc(10);
    end
  endtask : pulse
  // Reset, then room for the mode and thumbwheel latch
  task automatic reset_dut;
    rst = 1'b1;
    cyc(8);
    rst = 1'b0;
    cyc(10);
  endtask : reset_dut
  task automatic tally_and_finish;
    // A note still queued means an answer never came
    if (exq.size() != 0) begin
      failures++;
      $display("[ERR] %0t %0d answers missing", $time, exq.size());
    end
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // Tests
  initial begin
    void'($urandom(32'hC621DCD6));
    thumbwheel_bcd = {4'($urandom_range(9, 1)), 4'($urandom_range(9, 0))};
    lvl = 8'($urandom);
    reset_dut();
    input_line = lvl;
    internal_error = 1'b1;
    cyc(5);
    internal_error = 1'b0;
    chk(input_lamp, lvl);
    chk(counter_mode_lamp, 1'b0);
    chk(io_pairing_address, 7'(thumbwheel_bcd[7:4] * 10 + thumbwheel_bcd[3:0]));
    chk(tw_class, PCNT_TW_PAIRING);
    chk(link_lamp, 1'b0);
    link_cyclic = 1'b1;
    cyc(1);
    chk(link_lamp, 1'b1);
    // Fast phase flips every FAST_CYC + 1 edges, so nine edges flip it once
    link_cyclic = 1'b0;
    link_configuring = 1'b1;
    link_comm_lost = 1'b1;
    cyc(1);
    l = link_lamp;
    f = fault_lamp;
    cyc(9);
    chk(link_lamp, !l);
    chk(fault_lamp, !f);
    link_configuring = 1'b0;
    link_comm_lost = 1'b0;
    xf(0, 0, IN_TYPE_OFS, S_ID, 0);
    xf(0, 0, IN_LEVELS_OFS, {8'h00, lvl}, 0);
    xf(0, 0, IN_CNT1_HI_OFS, 16'h0000, 1);
    xf(1, 1, HOLD_CLR_OFS, 16'h0001, 1);
    xf(1, 0, IN_TYPE_OFS, 16'h0000, 1);
    $display("test static done");
    input_line = 8'h00;
    mode_switch = 1'b1;
    reset_dut();
    chk(counter_mode_lamp, 1'b1);
    mode_switch = 1'b0;
    xf(0, 0, IN_CNT1_LO_OFS, 16'h0000, 0);
    // Pending change: slow phase flips every SLOW_CYC + 1 edges
    l = counter_mode_lamp;
    f = fault_lamp;
    cyc(17);
    chk(counter_mode_lamp, !l);
    chk(fault_lamp, !f);
    n = $urandom_range(6, 2);
    l = input_lamp[0];
    pulse(0, n);
    chk(input_lamp[0], l ^ n[0]);
    pulse(6, 3);
    xf(0, 0, IN_TYPE_OFS, C_ID, 0);
    xf(0, 0, IN_CNT1_HI_OFS, 16'h0000, 0);
    xf(0, 0, IN_CNT1_LO_OFS, 16'(n), 0);
    xf(0, 0, IN_CNT7_LO_OFS, 16'h0003, 0);
    xf(1, 1, HOLD_CLR_OFS, 16'h0001, 0);
    xf(0, 0, IN_CNT1_LO_OFS, 16'h0000, 0);
    xf(0, 0, IN_CNT7_LO_OFS, 16'h0003, 0);
    pulse(0, 2);
    xf(1, 1, HOLD_CLR_OFS, 16'h0003, 0);
    xf(0, 0, IN_CNT1_LO_OFS, 16'h0000, 0);
    xf(0, 0, IN_CNT7_LO_OFS, 16'h0000, 0);
    xf(0, 1, HOLD_CLR_OFS, 16'h0003, 0);
    xf(0, 1, 4'h2, 16'h0000, 1);
    xf(0, 0, 4'h6, 16'h0000, 1);
    host_modbus_mode = 1'b0;
    pulse(0, 2);
    xf(0, 0, IN_CNT1_LO_OFS, 16'h0000, 0);
    host_modbus_mode = 1'b1;
    pulse(0, 3);
    pulse(6, 2);
    input_line = 8'h14;
    cyc(30);
    input_line = 8'h00;
    cyc(1);
    chk({input_lamp[4], input_lamp[2]}, 2'b11);
    xf(0, 0, IN_CNT1_LO_OFS, 16'h0000, 0);
    xf(0, 0, IN_CNT7_LO_OFS, 16'h0000, 0);
    // Mid-run power-up with a count standing, slave class on the wheel
    pulse(0, 2);
    xf(0, 0, IN_CNT1_LO_OFS, 16'h0002, 0);
    mode_switch = 1'b1;
    thumbwheel_bcd = 8'hA3;
    reset_dut();
    xf(0, 0, IN_CNT1_LO_OFS, 16'h0000, 0);
    chk(tw_class, PCNT_TW_SLAVE);
    chk(io_pairing_address, 7'h00);
    cyc(3);
    $display("test counter done");
    tally_and_finish();
  end
endmodule : tb_top
